// ===== verilog/fsm_mode_ctrl.sv
// Operating-mode controller: init, normal, stop, restart, fail-safe
module fsm_mode_ctrl
    import fsm_pkg::*;
#(
    parameter int FS_FILTER  = FS_FILTER_CYC,
    parameter int TSD_DELAY  = TSD_DELAY_CYC,
    parameter int RST_DELAY  = RST_DELAY_CYC
)
(
    // Clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET_N,
    // Analog monitors
    input  wire logic REG_ABOVE_RESET_THR,
    input  wire logic SUPPLY_ABOVE_UV_THR,
    input  wire logic REG_UNDERVOLTAGE_EVT,
    input  wire logic REG_SHORT_GND,
    input  wire logic THERMAL_SHUTDOWN_LEVEL_TWO,
    input  wire logic FS_WATCHDOG_FAILURE_FLAG_LIMIT,
    // Host frame decode
    input  wire logic       FRAME_VALID,
    input  wire logic       FRAME_CONTENT_BAD,
    input  wire logic [1:0] FRAME_MODE,
    input  wire logic       FRAME_MODE_WRITE,
    // Configuration bits
    input  wire logic DEVMODE_STRAP,
    input  wire logic DEVMODE_WATCHDOG_OFF,
    input  wire logic DEVMODE_WATCHDOG_IRQ_MASK,
    input  wire logic SOFT_RESET_PULSE_SELECT,
    input  wire logic SECOND_WAKE_PIN_IS_FAIL,
    input  wire logic CLEAR_FAILURE_FLAG,
    input  wire logic CLEAR_WATCHDOG_FAILURE,
    input  wire logic CLEAR_SPI_FAILURE,
    input  wire logic CYCLIC_SENSE_REQ,
    input  wire logic CYCLIC_WAKE_REQ,
    // Events
    input  wire logic WATCHDOG_TRIGGER_FAIL,
    input  wire logic WAKE_EVENT,
    input  wire logic SUPPLY_UV_EVT,
    // Outputs
    output logic       RESET_OUT_N,
    output logic       INTERRUPT_OUT_N,
    output logic       FAIL_OUTPUT,
    output logic       MAIN_REGULATOR_ON,
    output logic       WATCHDOG_ON,
    output logic       HIGH_SIDE_SWITCHES_EN,
    output logic       BRIDGE_DRIVER_CHARGE_PUMP_EN,
    output logic       CYCLIC_SENSE_ON,
    output logic       CYCLIC_WAKE_ON,
    output logic       BUS_FORCE_WAKE_CAPABLE,
    output logic       CAN_LIN_DEFAULT_ON,
    output logic       PARKING_BRAKE_ALLOWED,
    output logic       WAKE_SOURCES_DEFAULT_EN,
    output logic       WAKE_FLAGS_CLEAR,
    output logic       SOFT_RESET_LOAD,
    output logic       WATCHDOG_FAILURE_FLAG,
    output logic       SPI_FAILURE_FLAG,
    output logic       FAILURE_FLAG,
    output logic       REGULATOR_UNDERVOLTAGE_FLAG,
    output logic       SUPPLY_UNDERVOLTAGE_FLAG,
    output logic       DEVMODE_ACTIVE,
    output logic [2:0] MODE_STATE
);
    fsm_state_type state_r, state_nxt;
    logic          first_release_r;
    logic          devmode_block_r;
    logic          devmode_r;
    logic          devmode_caught_r;
    logic          wake_stored_r;
    logic          tsd_seen_r;
    logic          fs_entry;
    logic          fs_filter_done;
    logic          tsd_done;
    logic          rst_delay_done;
    logic [7:0]    soft_cnt_r;
    logic          soft_reset_req;
    logic          watchdog_failure_flag_eff;
    logic          wd_irq_pulse;
    logic          reg_uv_restart;

    ////////////////////////////////////////////////////////////////
    // Long delay timers
    fsm_timer u_fs_filter (
        .clk   (SYS_CLK),
        .rst_n (RESET_N),
        .run   (state_r == ST_FAILSAFE),
        .load  (CNT_W'(FS_FILTER)),
        .done  (fs_filter_done)
    );

    fsm_timer u_tsd (
        .clk   (SYS_CLK),
        .rst_n (RESET_N),
        .run   (state_r == ST_FAILSAFE && tsd_seen_r && !THERMAL_SHUTDOWN_LEVEL_TWO),
        .load  (CNT_W'(TSD_DELAY)),
        .done  (tsd_done)
    );

    // Reset delay only counts once regulator is above threshold
    fsm_timer u_rst_delay (
        .clk   (SYS_CLK),
        .rst_n (RESET_N),
        .run   (REG_ABOVE_RESET_THR && (state_r == ST_INIT || state_r == ST_RESTART)),
        .load  (CNT_W'(RST_DELAY)),
        .done  (rst_delay_done)
    );

    ////////////////////////////////////////////////////////////////
    // Derived events
    assign soft_reset_req = FRAME_VALID && FRAME_MODE_WRITE && FRAME_MODE == MODE_SOFT
                            && (state_r == ST_NORMAL || state_r == ST_STOP);
    // Development mode hides watchdog failures from mode logic
    assign watchdog_failure_flag_eff    = FS_WATCHDOG_FAILURE_FLAG_LIMIT && !devmode_r;
    assign reg_uv_restart = REG_UNDERVOLTAGE_EVT && first_release_r;
    assign fs_entry       = (state_nxt == ST_FAILSAFE) && (state_r != ST_FAILSAFE);
    assign wd_irq_pulse   = devmode_r && WATCHDOG_TRIGGER_FAIL && !DEVMODE_WATCHDOG_OFF
                            && !DEVMODE_WATCHDOG_IRQ_MASK;

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_INIT:
            begin
                if (REG_SHORT_GND || THERMAL_SHUTDOWN_LEVEL_TWO)
                    state_nxt = ST_FAILSAFE;
                else if (FRAME_VALID && RESET_OUT_N)
                    state_nxt = ST_NORMAL;
            end
            ST_NORMAL, ST_STOP:
            begin
                if (REG_SHORT_GND || THERMAL_SHUTDOWN_LEVEL_TWO || watchdog_failure_flag_eff)
                    state_nxt = ST_FAILSAFE;
                else if (soft_reset_req)
                    state_nxt = ST_INIT;
                else if (reg_uv_restart || (WATCHDOG_TRIGGER_FAIL && !devmode_r))
                    state_nxt = ST_RESTART;
                else if (FRAME_VALID && FRAME_MODE_WRITE && FRAME_MODE == MODE_STOP)
                    state_nxt = ST_STOP;
                else if (FRAME_VALID && FRAME_MODE_WRITE && FRAME_MODE == MODE_NORMAL)
                    state_nxt = ST_NORMAL;
            end
            ST_RESTART:
            begin
                if (REG_SHORT_GND || THERMAL_SHUTDOWN_LEVEL_TWO)
                    state_nxt = ST_FAILSAFE;
                else if (rst_delay_done)
                    state_nxt = ST_NORMAL;
            end
            ST_FAILSAFE:
            begin
                if (fs_filter_done && (wake_stored_r || WAKE_EVENT || tsd_done))
                    state_nxt = ST_RESTART;
            end
            default: state_nxt = ST_INIT;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state_r <= ST_INIT;
        else
            state_r <= state_nxt;
    end

    ////////////////////////////////////////////////////////////////
    // Fail-safe bookkeeping: stored wakes and thermal cause
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wake_stored_r <= 1'b0;
            tsd_seen_r    <= 1'b0;
        end
        else if (state_r != ST_FAILSAFE)
        begin
            wake_stored_r <= 1'b0;
            tsd_seen_r    <= THERMAL_SHUTDOWN_LEVEL_TWO;
        end
        else
        begin
            if (WAKE_EVENT)
                wake_stored_r <= 1'b1;
            if (THERMAL_SHUTDOWN_LEVEL_TWO)
                tsd_seen_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Development mode caught after reset release; short in init blocks it
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            devmode_r        <= 1'b0;
            devmode_caught_r <= 1'b0;
            devmode_block_r  <= 1'b0;
        end
        else
        begin
            if (!devmode_caught_r)
            begin
                devmode_caught_r <= 1'b1;
                devmode_r        <= DEVMODE_STRAP;
            end
            if (state_r == ST_INIT && REG_SHORT_GND)
            begin
                devmode_block_r <= 1'b1;
                devmode_r       <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // First release of reset output since power-up
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            first_release_r <= 1'b0;
        else if (RESET_OUT_N)
            first_release_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Soft reset output pulse counter
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            soft_cnt_r <= 8'h00;
        else if (soft_reset_req && !SOFT_RESET_PULSE_SELECT)
            soft_cnt_r <= 8'(SOFT_PULSE_CYC);
        else if (soft_cnt_r != 8'h00)
            soft_cnt_r <= soft_cnt_r - 8'h01;
    end

    ////////////////////////////////////////////////////////////////
    // Reset output: low below threshold, in restart, during pulse
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            RESET_OUT_N <= 1'b0;
        else if (!REG_ABOVE_RESET_THR || state_nxt == ST_RESTART || state_nxt == ST_FAILSAFE)
            RESET_OUT_N <= 1'b0;
        else if (soft_reset_req && !SOFT_RESET_PULSE_SELECT)
            RESET_OUT_N <= 1'b0;
        else if (soft_cnt_r > 8'h01)
            RESET_OUT_N <= 1'b0;
        else if (rst_delay_done || state_r == ST_NORMAL || state_r == ST_STOP)
            RESET_OUT_N <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Status flags; hardware set wins over clear
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            WATCHDOG_FAILURE_FLAG       <= 1'b0;
            SPI_FAILURE_FLAG            <= 1'b0;
            FAILURE_FLAG                <= 1'b0;
            REGULATOR_UNDERVOLTAGE_FLAG <= 1'b0;
            SUPPLY_UNDERVOLTAGE_FLAG    <= 1'b0;
        end
        else
        begin
            if (WATCHDOG_TRIGGER_FAIL && !(devmode_r && DEVMODE_WATCHDOG_OFF))
                WATCHDOG_FAILURE_FLAG <= 1'b1;
            else if (CLEAR_WATCHDOG_FAILURE)
                WATCHDOG_FAILURE_FLAG <= 1'b0;
            if (state_r == ST_INIT && FRAME_VALID && RESET_OUT_N
                && (FRAME_CONTENT_BAD || (FRAME_MODE_WRITE && FRAME_MODE == MODE_SLEEP)))
                SPI_FAILURE_FLAG <= 1'b1;
            else if (CLEAR_SPI_FAILURE)
                SPI_FAILURE_FLAG <= 1'b0;
            if (state_r == ST_FAILSAFE && state_nxt != ST_FAILSAFE)
                FAILURE_FLAG <= 1'b1;
            else if (CLEAR_FAILURE_FLAG)
                FAILURE_FLAG <= 1'b0;
            if (REG_UNDERVOLTAGE_EVT && (REG_ABOVE_RESET_THR || SUPPLY_ABOVE_UV_THR))
                REGULATOR_UNDERVOLTAGE_FLAG <= 1'b1;
            else if (soft_reset_req)
                REGULATOR_UNDERVOLTAGE_FLAG <= 1'b0;
            if (SUPPLY_UV_EVT && (state_r != ST_INIT || RESET_OUT_N))
                SUPPLY_UNDERVOLTAGE_FLAG <= 1'b1;
            else if (soft_reset_req)
                SUPPLY_UNDERVOLTAGE_FLAG <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Function enables per mode
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            MAIN_REGULATOR_ON            <= 1'b1;
            WATCHDOG_ON                  <= 1'b0;
            HIGH_SIDE_SWITCHES_EN        <= 1'b0;
            BRIDGE_DRIVER_CHARGE_PUMP_EN <= 1'b0;
            CYCLIC_SENSE_ON              <= 1'b0;
            CYCLIC_WAKE_ON               <= 1'b0;
            BUS_FORCE_WAKE_CAPABLE       <= 1'b0;
            PARKING_BRAKE_ALLOWED        <= 1'b0;
            CAN_LIN_DEFAULT_ON           <= 1'b0;
        end
        else
        begin
            MAIN_REGULATOR_ON     <= (state_nxt != ST_FAILSAFE);
            WATCHDOG_ON           <= (state_nxt == ST_NORMAL || state_nxt == ST_STOP)
                                     && !(devmode_r && DEVMODE_WATCHDOG_OFF);
            HIGH_SIDE_SWITCHES_EN <= (state_nxt == ST_NORMAL || state_nxt == ST_STOP);
            BRIDGE_DRIVER_CHARGE_PUMP_EN <= (state_nxt == ST_NORMAL);
            // Cyclic functions die in restart and fail-safe
            CYCLIC_SENSE_ON       <= CYCLIC_SENSE_REQ && (state_nxt == ST_NORMAL
                                     || state_nxt == ST_STOP);
            CYCLIC_WAKE_ON        <= CYCLIC_WAKE_REQ && (state_nxt == ST_NORMAL
                                     || state_nxt == ST_STOP);
            BUS_FORCE_WAKE_CAPABLE <= (state_nxt == ST_FAILSAFE);
            PARKING_BRAKE_ALLOWED <= (state_nxt != ST_FAILSAFE);
            // In development mode the default stays on from init into normal until the mode moves on
            CAN_LIN_DEFAULT_ON    <= devmode_r && (state_nxt == ST_INIT
                                     || (CAN_LIN_DEFAULT_ON && state_nxt == ST_NORMAL));
        end
    end

    ////////////////////////////////////////////////////////////////
    // Entry pulses, fail output, interrupt, visible state
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            WAKE_SOURCES_DEFAULT_EN <= 1'b0;
            WAKE_FLAGS_CLEAR        <= 1'b0;
            SOFT_RESET_LOAD         <= 1'b0;
            FAIL_OUTPUT             <= 1'b0;
            INTERRUPT_OUT_N         <= 1'b1;
            DEVMODE_ACTIVE          <= 1'b0;
            MODE_STATE              <= 3'h0;
        end
        else
        begin
            WAKE_SOURCES_DEFAULT_EN <= fs_entry;
            // Init drops wakes, fail-safe entry clears flags
            WAKE_FLAGS_CLEAR <= fs_entry || (state_r == ST_INIT && WAKE_EVENT);
            SOFT_RESET_LOAD  <= soft_reset_req;
            if (fs_entry && SECOND_WAKE_PIN_IS_FAIL)
                FAIL_OUTPUT <= 1'b1;
            else if (state_r != ST_FAILSAFE && !FAILURE_FLAG)
                FAIL_OUTPUT <= 1'b0;
            INTERRUPT_OUT_N <= !wd_irq_pulse;
            DEVMODE_ACTIVE  <= devmode_r && !devmode_block_r;
            MODE_STATE      <= state_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    // Outputs follow the next state, so the regulator check keys on state_nxt
    AST_FS_REG_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_nxt == ST_FAILSAFE |=> !MAIN_REGULATOR_ON && BUS_FORCE_WAKE_CAPABLE)
        else $error("regulator on in fail-safe");
    AST_CYC_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_nxt == ST_RESTART |=> !CYCLIC_SENSE_ON && !CYCLIC_WAKE_ON)
        else $error("cyclic still on in restart");
    AST_FS_WAKE_CLR: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        fs_entry |=> WAKE_FLAGS_CLEAR && WAKE_SOURCES_DEFAULT_EN)
        else $error("fail-safe entry actions missing");
    AST_FO_SET: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        fs_entry && SECOND_WAKE_PIN_IS_FAIL |=> FAIL_OUTPUT)
        else $error("fail output not asserted");
    AST_PARK_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_r == ST_FAILSAFE && $past(state_r) == ST_FAILSAFE
        |-> !PARKING_BRAKE_ALLOWED)
        else $error("parking brake allowed in fail-safe");
    AST_FS_STAY: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        fs_entry |=> state_r == ST_FAILSAFE [*8])
        else $error("fail-safe left before filter");
    AST_DEV_NO_WD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        devmode_r && state_r == ST_NORMAL && WATCHDOG_TRIGGER_FAIL && !REG_SHORT_GND
        && !THERMAL_SHUTDOWN_LEVEL_TWO && !reg_uv_restart |=> state_r != ST_RESTART)
        else $error("watchdog failure caused restart in dev mode");
    // Back-to-back failures may keep the line low one more cycle
    AST_DEV_IRQ: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        wd_irq_pulse |=> !INTERRUPT_OUT_N ##1 (INTERRUPT_OUT_N || $past(wd_irq_pulse)))
        else $error("wrong watchdog interrupt pulse");
    AST_RST_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !REG_ABOVE_RESET_THR |=> !RESET_OUT_N)
        else $error("reset output high below threshold");
    AST_INIT_NORMAL: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_r == ST_INIT && FRAME_VALID && RESET_OUT_N && !REG_SHORT_GND
        && !THERMAL_SHUTDOWN_LEVEL_TWO |=> state_r == ST_NORMAL)
        else $error("frame did not move init to normal");
    AST_SOFT_PULSE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        soft_reset_req && SOFT_RESET_PULSE_SELECT && REG_ABOVE_RESET_THR |=> RESET_OUT_N)
        else $error("reset pulse despite select");
    AST_FAIL_FLAG: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_r == ST_FAILSAFE && state_nxt == ST_RESTART |=> FAILURE_FLAG)
        else $error("failure flag not set on exit");

    COV_FS_EXIT: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_r == ST_FAILSAFE ##1 state_r == ST_RESTART);
    COV_INIT_NORMAL: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
        state_r == ST_INIT ##1 state_r == ST_NORMAL);
    COV_SOFT: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) soft_reset_req);
endmodule

// ===== include/fsm_pkg.sv
package fsm_pkg;
    localparam int CLK_MHZ         = 125;
    localparam int FS_FILTER_MS    = 100;   // Fail-safe least stay
    localparam int TSD_DELAY_MS    = 1000;  // Thermal restart delay
    localparam int FS_FILTER_CYC   = FS_FILTER_MS * 1000 * CLK_MHZ;
    localparam int TSD_DELAY_CYC   = TSD_DELAY_MS * 1000 * CLK_MHZ;
    localparam int RST_DELAY_CYC   = 1250;  // Reset delay after threshold
    localparam int SOFT_PULSE_CYC  = 125;   // Soft reset output pulse
    localparam int CNT_W           = 32;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_STOP   = 2'h2;
    localparam logic [1:0] MODE_SOFT   = 2'h3;
    typedef enum logic [2:0] {ST_INIT, ST_NORMAL, ST_STOP, ST_RESTART, ST_FAILSAFE} fsm_state_type;
endpackage

// ===== verilog/fsm_timer.sv
// Down counter used for all long delays; reload while not run
module fsm_timer
    import fsm_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] load,
    // Status
    output logic                  done
);
    logic [CNT_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////
    // Count while run; done holds at zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (!run)
            cnt_r <= load;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    assign done = run && (cnt_r == '0);
endmodule

// ===== testbench/fsm_host_model.sv
// Host controller stand-in: one decoded frame per call
module fsm_host_model
(
    // Clock and reset line
    input  wire logic  clk,
    input  wire logic  reset_out_n,
    // Decoded frame
    output logic       frame_valid,
    output logic       frame_content_bad,
    output logic [1:0] frame_mode,
    output logic       frame_mode_write
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////
    // Quiet lines until the first call
    initial
    begin
        frame_valid = 1'b0;
        frame_content_bad = 1'b0;
        frame_mode = 2'h0;
        frame_mode_write = 1'b0;
    end
    // A real host stays silent while held in reset
    task automatic send(input logic [1:0] mode, input logic bad);
        while (reset_out_n !== 1'b1)
            @(negedge clk);
        frame_valid = 1'b1;
        frame_mode_write = 1'b1;
        frame_mode = mode;
        frame_content_bad = bad;
        @(negedge clk);
        frame_valid = 1'b0;
        frame_mode_write = 1'b0;
        frame_content_bad = 1'b0;
        frame_mode = ~mode; // Stale bus, never the held code
    endtask
endmodule

// ===== testbench/failsafe_init_mode_control_tb_top.sv
module failsafe_init_mode_control_tb_top;
    import fsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Named as the design ports so the instance binds by name
    logic SYS_CLK, RESET_N, REG_ABOVE_RESET_THR, SUPPLY_ABOVE_UV_THR, REG_UNDERVOLTAGE_EVT;
    logic REG_SHORT_GND, THERMAL_SHUTDOWN_LEVEL_TWO, FS_WATCHDOG_FAILURE_FLAG_LIMIT, FRAME_VALID;
    logic FRAME_CONTENT_BAD, FRAME_MODE_WRITE, DEVMODE_STRAP, DEVMODE_WATCHDOG_OFF;
    logic DEVMODE_WATCHDOG_IRQ_MASK, SOFT_RESET_PULSE_SELECT, SECOND_WAKE_PIN_IS_FAIL;
    logic CLEAR_FAILURE_FLAG, CLEAR_WATCHDOG_FAILURE, CLEAR_SPI_FAILURE, CYCLIC_SENSE_REQ;
    logic CYCLIC_WAKE_REQ, WATCHDOG_TRIGGER_FAIL, WAKE_EVENT, SUPPLY_UV_EVT, RESET_OUT_N;
    logic INTERRUPT_OUT_N, FAIL_OUTPUT, MAIN_REGULATOR_ON, WATCHDOG_ON, HIGH_SIDE_SWITCHES_EN;
    logic BRIDGE_DRIVER_CHARGE_PUMP_EN, CYCLIC_SENSE_ON, CYCLIC_WAKE_ON, BUS_FORCE_WAKE_CAPABLE;
    logic CAN_LIN_DEFAULT_ON, PARKING_BRAKE_ALLOWED, WAKE_SOURCES_DEFAULT_EN, WAKE_FLAGS_CLEAR;
    logic SOFT_RESET_LOAD, WATCHDOG_FAILURE_FLAG, SPI_FAILURE_FLAG, FAILURE_FLAG, DEVMODE_ACTIVE;
    logic REGULATOR_UNDERVOLTAGE_FLAG, SUPPLY_UNDERVOLTAGE_FLAG, irq_seen;
    logic [1:0] FRAME_MODE;
    logic [2:0] MODE_STATE;
    int         n_fail = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    ////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial
    begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    // Short counts keep the fail-safe stay within a short run
    fsm_mode_ctrl #(.FS_FILTER(20), .TSD_DELAY(30), .RST_DELAY(10)) uut (.*);
    fsm_host_model host (.clk(SYS_CLK), .reset_out_n(RESET_OUT_N), .frame_valid(FRAME_VALID),
        .frame_content_bad(FRAME_CONTENT_BAD), .frame_mode(FRAME_MODE),
        .frame_mode_write(FRAME_MODE_WRITE));
    ////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask
    // Bounded wait for a mode, then judge it
    task automatic wait_mode(input logic [2:0] m);
        for (int i = 0; i < 60 && MODE_STATE !== m; i++)
            tick(1);
        chk(MODE_STATE, m);
    endtask
    // Power-up with a wake in init, then a sleep request as first frame
    task automatic power_up(input logic dev);
        DEVMODE_STRAP = dev;
        REG_ABOVE_RESET_THR = 1'b0;
        SUPPLY_ABOVE_UV_THR = 1'b0;
        RESET_N = 1'b0;
        tick(4);
        RESET_N = 1'b1;
        WAKE_EVENT = 1'b1;
        REG_UNDERVOLTAGE_EVT = 1'b1;
        SUPPLY_UV_EVT = 1'b1;
        tick(1);
        {WAKE_EVENT, REG_UNDERVOLTAGE_EVT, SUPPLY_UV_EVT} = 3'h0;
        tick(30);
        chk(RESET_OUT_N, 1'b0);
        chk(REGULATOR_UNDERVOLTAGE_FLAG, 1'b0);
        chk(SUPPLY_UNDERVOLTAGE_FLAG, 1'b0);
        chk(MODE_STATE, ST_INIT);
        chk(CAN_LIN_DEFAULT_ON, dev);
        REG_ABOVE_RESET_THR = 1'b1;
        tick(8);
        chk(RESET_OUT_N, 1'b0);
        tick(6);
        chk(RESET_OUT_N, 1'b1);
        host.send(MODE_SLEEP, dev);
        wait_mode(ST_NORMAL);
        chk(SPI_FAILURE_FLAG, 1'b1);
        chk(CAN_LIN_DEFAULT_ON, dev);
    endtask
    // Regulator short, early wake held back by the filter
    task automatic fail_safe;
        REG_SHORT_GND = 1'b1;
        tick(1);
        REG_SHORT_GND = 1'b0;
        tick(3);
        chk(MODE_STATE, ST_FAILSAFE);
        chk(MAIN_REGULATOR_ON | WATCHDOG_ON | HIGH_SIDE_SWITCHES_EN, 1'b0);
        chk(BRIDGE_DRIVER_CHARGE_PUMP_EN | CYCLIC_SENSE_ON | CYCLIC_WAKE_ON, 1'b0);
        chk(BUS_FORCE_WAKE_CAPABLE, 1'b1);
        chk(FAIL_OUTPUT, 1'b1);
        chk(PARKING_BRAKE_ALLOWED, 1'b0);
        WAKE_EVENT = 1'b1;
        tick(1);
        WAKE_EVENT = 1'b0;
        tick(8);
        chk(MODE_STATE, ST_FAILSAFE);
        wait_mode(ST_RESTART);
        chk(CYCLIC_SENSE_ON | CYCLIC_WAKE_ON, 1'b0);
        chk(FAILURE_FLAG, 1'b1);
        wait_mode(ST_NORMAL);
        chk(FAIL_OUTPUT, 1'b1);
        CLEAR_FAILURE_FLAG = 1'b1;
        tick(1);
        CLEAR_FAILURE_FLAG = 1'b0;
        tick(2);
        chk(FAIL_OUTPUT, 1'b0);
    endtask
    // Soft reset with and without the reset output pulse
    task automatic soft_reset(input logic sel);
        SOFT_RESET_PULSE_SELECT = sel;
        host.send(MODE_SOFT, 1'b0);
        tick(3);
        chk(MODE_STATE, ST_INIT);
        chk(RESET_OUT_N, sel);
        host.send(MODE_NORMAL, 1'b0);
        wait_mode(ST_NORMAL);
    endtask
    // Development watchdog: plain, masked, switched off
    task automatic dev_watchdog;
        power_up(1'b1);
        chk(WATCHDOG_ON, 1'b1);
        for (int m = 0; m < 3; m++)
        begin
            DEVMODE_WATCHDOG_IRQ_MASK = (m == 1);
            DEVMODE_WATCHDOG_OFF = (m == 2);
            CLEAR_WATCHDOG_FAILURE = 1'b1;
            tick(1);
            CLEAR_WATCHDOG_FAILURE = 1'b0;
            WATCHDOG_TRIGGER_FAIL = 1'b1;
            irq_seen = 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                tick(1);
                WATCHDOG_TRIGGER_FAIL = 1'b0;
                irq_seen = irq_seen | (INTERRUPT_OUT_N === 1'b0);
            end
            chk(irq_seen, m == 0);
            chk(WATCHDOG_FAILURE_FLAG, m < 2);
            chk(MODE_STATE, ST_NORMAL);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Hang guard, well above the expected run length
    always @(posedge SYS_CLK)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_fail++;
            complete_run();
        end
    end
    // Main sequence; every input starts low, cyclic requests and second wake pin as fail on
    initial
    begin
        {RESET_N, REG_ABOVE_RESET_THR, SUPPLY_ABOVE_UV_THR, REG_UNDERVOLTAGE_EVT, REG_SHORT_GND,
            THERMAL_SHUTDOWN_LEVEL_TWO, FS_WATCHDOG_FAILURE_FLAG_LIMIT, DEVMODE_STRAP, DEVMODE_WATCHDOG_OFF,
            DEVMODE_WATCHDOG_IRQ_MASK, SOFT_RESET_PULSE_SELECT, CLEAR_FAILURE_FLAG,
            CLEAR_WATCHDOG_FAILURE, CLEAR_SPI_FAILURE, WATCHDOG_TRIGGER_FAIL, WAKE_EVENT,
            SUPPLY_UV_EVT} = '0;
        {CYCLIC_SENSE_REQ, CYCLIC_WAKE_REQ, SECOND_WAKE_PIN_IS_FAIL} = 3'h7;
        power_up(1'b0);
        SUPPLY_ABOVE_UV_THR = 1'b1;
        fail_safe();
        REG_UNDERVOLTAGE_EVT = 1'b1;
        tick(1);
        REG_UNDERVOLTAGE_EVT = 1'b0;
        wait_mode(ST_RESTART);
        wait_mode(ST_NORMAL);
        soft_reset(1'b0);
        soft_reset(1'b1);
        dev_watchdog();
        complete_run();
    end
endmodule
